// [hdl/cpu_status_flags.v]
// Operation
// RL1: an 11-bit flag register shows the current processor state
// RL2: carry flag keeps carry, borrow or shifted-out bit of the operation
// RL3: software writes only zero into the debug flag
// RL4: zero flag is 1 for a zero result, else 0
// RL5: sign flag is 1 for a negative result, else 0
// RL6: bank flag picks general register bank 0 or bank 1
// RL7: overflow flag is 1 on overflow, else 0
// RL8: stack flag picks user or interrupt stack pointer as current one
// RL9: flags an operation does not define keep their value
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "cpu_status_flags_map.vh"

module cpu_status_flags #(
    parameter DATA_W = 16
) (
    // clock and reset
    input wire CLK_I,
    input wire SYS_RST_I,
    // axi4-lite write address
    input wire [7:0] AWADDR_I,
    input wire AWVALID_I,
    output reg AWREADY_O,
    // axi4-lite write data
    input wire [31:0] WDATA_I,
    input wire [3:0] WSTRB_I,
    input wire WVALID_I,
    output reg WREADY_O,
    // axi4-lite write response
    output reg [1:0] BRESP_O,
    output reg BVALID_O,
    input wire BREADY_I,
    // axi4-lite read address
    input wire [7:0] ARADDR_I,
    input wire ARVALID_I,
    output reg ARREADY_O,
    // axi4-lite read data
    output reg [31:0] RDATA_O,
    output reg [1:0] RRESP_O,
    output reg RVALID_O,
    input wire RREADY_I,
    // processor state towards the core
    output wire [`FLAGS_WIDTH-1:0] FLAGS_O,
    output wire BANK_SEL_O,
    output wire STACK_SEL_O,
    output reg [DATA_W-1:0] CUR_SP_O
);

// ----------------------------------------
// state
// ----------------------------------------
reg [`FLAGS_WIDTH-1:0] flags;
reg [`FLAGS_WIDTH-1:0] next_flags;
reg [DATA_W-1:0] user_stack_pointer;
reg [DATA_W-1:0] interrupt_stack_pointer;
reg [DATA_W-1:0] next_usp;
reg [DATA_W-1:0] next_isp;
reg [DATA_W-1:0] result;
reg [`OP_WIDTH-1:0] last_op;
reg [DATA_W-1:0] bank_mem [0:7];
reg aw_full;
reg w_full;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
integer i;

// ----------------------------------------
// byte-lane merge
// ----------------------------------------
function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (s[k]) begin
                merge[k*8 +: 8] = d[k*8 +: 8];
            end
        end
    end
endfunction

// ----------------------------------------
// write channel handshake
// ----------------------------------------
wire aw_take = AWVALID_I && AWREADY_O;
wire w_take = WVALID_I && WREADY_O;
wire have_aw = aw_full || aw_take;
wire have_w = w_full || w_take;
wire do_write = have_aw && have_w && !BVALID_O;
wire next_bvalid = do_write || (BVALID_O && !BREADY_I);
wire next_aw_full = have_aw && !do_write;
wire next_w_full = have_w && !do_write;
wire [7:0] wa = aw_take ? AWADDR_I : aw_addr;
wire [31:0] wd = w_take ? WDATA_I : w_data;
wire [3:0] ws = w_take ? WSTRB_I : w_strb;
wire [7:0] wa_word = {wa[7:2], 2'b00};

// ----------------------------------------
// write decode
// ----------------------------------------
wire sel_flags = (wa_word == `OFS_FLAGS);
wire sel_op = (wa_word == `OFS_OP);
wire sel_usp = (wa_word == `OFS_USP);
wire sel_isp = (wa_word == `OFS_ISP);
wire sel_data = (wa[7:4] == `DATA_SEL_HI);
// read-only words take a write with okay and keep their value
wire sel_ro = (wa_word == `OFS_CUR_SP) || (wa_word == `OFS_RESULT);
wire w_mapped = sel_flags || sel_op || sel_usp || sel_isp || sel_data || sel_ro;
// an op word without its low byte lane is dropped as a whole
wire op_fire = do_write && sel_op && ws[0];
wire [31:0] flags_merged = merge({{(32-`FLAGS_WIDTH){1'b0}}, flags}, wd, ws);
wire [31:0] usp_merged = merge({{(32-DATA_W){1'b0}}, user_stack_pointer}, wd, ws);
wire [31:0] isp_merged = merge({{(32-DATA_W){1'b0}}, interrupt_stack_pointer}, wd, ws);
wire [2:0] data_idx = {flags[`BIT_BANK], wa[3:2]};
wire [31:0] data_merged = merge({{(32-DATA_W){1'b0}}, bank_mem[data_idx]}, wd, ws);

// ----------------------------------------
// operation through the active bank
// ----------------------------------------
wire [2:0] opc = wd[`OP_CODE_LSB +: 3];
wire [1:0] src_a = wd[`OP_SRC_A_LSB +: 2];
wire [1:0] src_b = wd[`OP_SRC_B_LSB +: 2];
wire [1:0] dst = wd[`OP_DST_LSB +: 2];
// operands and destination use the bank held before this edge
wire [DATA_W-1:0] opnd_a = bank_mem[{flags[`BIT_BANK], src_a}]; // RL6
wire [DATA_W-1:0] opnd_b = bank_mem[{flags[`BIT_BANK], src_b}]; // RL6
wire [DATA_W-1:0] alu_result;
wire alu_carry;
wire alu_zero;
wire alu_sign;
wire alu_ovfl;
wire [3:0] alu_def;

flag_alu #(
    .W(DATA_W)
) u_alu (
    .op_i(opc),
    .a_i(opnd_a),
    .b_i(opnd_b),
    .result_o(alu_result),
    .carry_o(alu_carry),
    .zero_o(alu_zero),
    .sign_o(alu_sign),
    .ovfl_o(alu_ovfl),
    .def_o(alu_def)
);

// ----------------------------------------
// next flag, stack pointer values
// ----------------------------------------
always @* begin
    next_flags = flags; // RL9
    if (op_fire) begin
        if (alu_def[0]) begin
            next_flags[`BIT_CARRY] = alu_carry; // RL2
        end
        if (alu_def[1]) begin
            next_flags[`BIT_ZERO] = alu_zero; // RL4
        end
        if (alu_def[2]) begin
            next_flags[`BIT_SIGN] = alu_sign; // RL5
        end
        if (alu_def[3]) begin
            next_flags[`BIT_OVFL] = alu_ovfl; // RL7
        end
    end
    // the debug bit is stored as written; software is trusted to keep it 0
    if (do_write && sel_flags) begin
        next_flags = flags_merged[`FLAGS_WIDTH-1:0]; // RL1 RL3
    end
end

always @* begin
    next_usp = user_stack_pointer;
    next_isp = interrupt_stack_pointer;
    if (do_write && sel_usp) begin
        next_usp = usp_merged[DATA_W-1:0];
    end
    if (do_write && sel_isp) begin
        next_isp = isp_merged[DATA_W-1:0];
    end
end

// ----------------------------------------
// register file update
// ----------------------------------------
always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
        flags <= `RST_FLAGS;
        user_stack_pointer <= `RST_SP;
        interrupt_stack_pointer <= `RST_SP;
        CUR_SP_O <= `RST_SP;
        result <= `RST_WORD;
        last_op <= {`OP_WIDTH{1'b0}};
        for (i = 0; i < 8; i = i + 1) begin
            bank_mem[i] <= `RST_WORD;
        end
    end else begin
        flags <= next_flags; // RL1
        user_stack_pointer <= next_usp;
        interrupt_stack_pointer <= next_isp;
        // registered from next values so it changes with the stack flag
        CUR_SP_O <= next_flags[`BIT_STACK] ? next_isp : next_usp; // RL8
        if (op_fire) begin
            result <= alu_result;
            last_op <= wd[`OP_WIDTH-1:0];
            bank_mem[{flags[`BIT_BANK], dst}] <= alu_result; // RL6
        end
        if (do_write && sel_data) begin
            bank_mem[data_idx] <= data_merged[DATA_W-1:0]; // RL6
        end
    end
end

assign FLAGS_O = flags;
assign BANK_SEL_O = flags[`BIT_BANK]; // RL6
assign STACK_SEL_O = flags[`BIT_STACK]; // RL8

// ----------------------------------------
// write channel registers
// ----------------------------------------
always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
        AWREADY_O <= 1'b0;
        WREADY_O <= 1'b0;
        BVALID_O <= 1'b0;
        BRESP_O <= `RESP_OKAY;
    end else begin
        aw_full <= next_aw_full;
        w_full <= next_w_full;
        if (aw_take) begin
            aw_addr <= AWADDR_I;
        end
        if (w_take) begin
            w_data <= WDATA_I;
            w_strb <= WSTRB_I;
        end
        // each side stalls until its pair arrives and the response drains
        AWREADY_O <= !next_aw_full && !next_bvalid;
        WREADY_O <= !next_w_full && !next_bvalid;
        BVALID_O <= next_bvalid;
        if (do_write) begin
            BRESP_O <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
    end
end

// ----------------------------------------
// read channel
// ----------------------------------------
// data is latched at the address edge so it stands until rready
wire ar_take = ARVALID_I && ARREADY_O;
wire next_rvalid = ar_take || (RVALID_O && !RREADY_I);
wire [7:0] ra_word = {ARADDR_I[7:2], 2'b00};
wire [2:0] rd_idx = {flags[`BIT_BANK], ARADDR_I[3:2]};
reg [31:0] rd_mux;
reg rd_ok;

always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (ARADDR_I[7:4] == `DATA_SEL_HI) begin
        rd_mux[DATA_W-1:0] = bank_mem[rd_idx]; // RL6
    end else begin
        case (ra_word)
            `OFS_FLAGS: rd_mux[`FLAGS_WIDTH-1:0] = flags; // RL1
            `OFS_OP: rd_mux[`OP_WIDTH-1:0] = last_op;
            `OFS_USP: rd_mux[DATA_W-1:0] = user_stack_pointer;
            `OFS_ISP: rd_mux[DATA_W-1:0] = interrupt_stack_pointer;
            `OFS_CUR_SP: rd_mux[DATA_W-1:0] = CUR_SP_O; // RL8
            `OFS_RESULT: rd_mux[DATA_W-1:0] = result;
            default: rd_ok = 1'b0;
        endcase
    end
end

always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
        ARREADY_O <= 1'b0;
        RVALID_O <= 1'b0;
        RDATA_O <= 32'h00000000;
        RRESP_O <= `RESP_OKAY;
    end else begin
        ARREADY_O <= !next_rvalid;
        RVALID_O <= next_rvalid;
        if (ar_take) begin
            RDATA_O <= rd_mux;
            RRESP_O <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
    end
end

endmodule // cpu_status_flags

// [hdl/cpu_status_flags_map.vh]
`ifndef CPU_STATUS_FLAGS_MAP_VH
`define CPU_STATUS_FLAGS_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_FLAGS 8'h00
`define OFS_OP 8'h04
`define OFS_USP 8'h08
`define OFS_ISP 8'h0c
`define OFS_CUR_SP 8'h10
`define OFS_RESULT 8'h14
`define DATA_SEL_HI 4'h2

// ----------------------------------------
// flag register bit positions
// ----------------------------------------
`define FLAGS_WIDTH 11
`define BIT_CARRY 0
`define BIT_DEBUG 1
`define BIT_ZERO 2
`define BIT_SIGN 3
`define BIT_BANK 4
`define BIT_OVFL 5
`define BIT_IRQ_EN 6
`define BIT_STACK 7

// ----------------------------------------
// operation register fields
// ----------------------------------------
`define OP_CODE_LSB 0
`define OP_SRC_A_LSB 4
`define OP_SRC_B_LSB 6
`define OP_DST_LSB 8
`define OP_WIDTH 10

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OPC_MOV 3'h0
`define OPC_ADD 3'h1
`define OPC_SUB 3'h2
`define OPC_AND 3'h3
`define OPC_OR 3'h4
`define OPC_XOR 3'h5
`define OPC_SHL 3'h6
`define OPC_SHR 3'h7

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define RST_FLAGS 11'h000
`define RST_SP 16'h0000
`define RST_WORD 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [hdl/flag_alu.v]
`timescale 1ns/1ps
`include "cpu_status_flags_map.vh"

module flag_alu #(
    parameter W = 16
) (
    // operation and operands
    input wire [2:0] op_i,
    input wire [W-1:0] a_i,
    input wire [W-1:0] b_i,
    // result and flag values
    output reg [W-1:0] result_o,
    output reg carry_o,
    output reg zero_o,
    output reg sign_o,
    output reg ovfl_o,
    // which flags this operation defines: {ovfl, sign, zero, carry}
    output reg [3:0] def_o
);

reg [W:0] wide;

always @* begin
    wide = {(W+1){1'b0}};
    result_o = b_i;
    carry_o = 1'b0;
    ovfl_o = 1'b0;
    def_o = 4'h6;
    case (op_i)
        `OPC_MOV: begin
            result_o = b_i;
        end
        `OPC_ADD: begin
            wide = {1'b0, a_i} + {1'b0, b_i};
            result_o = wide[W-1:0];
            carry_o = wide[W]; // RL2
            ovfl_o = (a_i[W-1] == b_i[W-1]) && (wide[W-1] != a_i[W-1]); // RL7
            def_o = 4'hf;
        end
        `OPC_SUB: begin
            wide = {1'b0, a_i} - {1'b0, b_i};
            result_o = wide[W-1:0];
            // carry holds the borrow: 1 when b exceeds a
            carry_o = wide[W]; // RL2
            ovfl_o = (a_i[W-1] != b_i[W-1]) && (wide[W-1] != a_i[W-1]); // RL7
            def_o = 4'hf;
        end
        `OPC_AND: begin
            result_o = a_i & b_i;
        end
        `OPC_OR: begin
            result_o = a_i | b_i;
        end
        `OPC_XOR: begin
            result_o = a_i ^ b_i;
        end
        `OPC_SHL: begin
            result_o = {a_i[W-2:0], 1'b0};
            carry_o = a_i[W-1]; // RL2
            def_o = 4'h7;
        end
        `OPC_SHR: begin
            result_o = {1'b0, a_i[W-1:1]};
            carry_o = a_i[0]; // RL2
            def_o = 4'h7;
        end
        default: begin
            result_o = b_i;
        end
    endcase
    zero_o = (result_o == {W{1'b0}}); // RL4
    sign_o = result_o[W-1]; // RL5
end

endmodule // flag_alu

// [verification/cpu_status_flags_sva.sv]
`timescale 1ns/1ps
module cpu_status_flags_sva #(
    parameter DATA_W = 16
) (
    // clock and reset
    input wire CLK_I,
    input wire SYS_RST_I,
    // bus handshakes
    input wire [7:0] AWADDR_I,
    input wire AWVALID_I,
    input wire AWREADY_O,
    input wire WVALID_I,
    input wire WREADY_O,
    input wire [1:0] BRESP_O,
    input wire BVALID_O,
    input wire [7:0] ARADDR_I,
    input wire ARVALID_I,
    input wire ARREADY_O,
    input wire [31:0] RDATA_O,
    input wire [1:0] RRESP_O,
    input wire RVALID_O,
    // processor state
    input wire [10:0] FLAGS_O,
    input wire BANK_SEL_O,
    input wire STACK_SEL_O,
    input wire [DATA_W-1:0] CUR_SP_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // bank and stack select move only with an executed write, which raises bvalid
    bank_switch_a: assert property ($changed(BANK_SEL_O) |-> $rose(BVALID_O)
        && BANK_SEL_O == FLAGS_O[4]) else $error("bank select moved off a write");
    stack_switch_a: assert property ($changed(STACK_SEL_O) |-> $rose(BVALID_O)
        && STACK_SEL_O == FLAGS_O[7]) else $error("stack select moved off a write");
    flags_width_a: assert property (ARVALID_I && ARREADY_O && ARADDR_I == 8'h00
        |=> RVALID_O && RDATA_O[31:11] == 21'h0) else $error("flag word too wide");
    // state only moves on a bus write edge
    flags_hold_a: assert property (!AWVALID_I && !WVALID_I |=> $stable(FLAGS_O))
        else $error("flags moved without write");
    sp_hold_a: assert property (!AWVALID_I && !WVALID_I |=> $stable(CUR_SP_O))
        else $error("stack pointer moved");
    read_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
        else $error("read answer late");
    write_answer_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
        |=> BVALID_O && !AWREADY_O && !WREADY_O) else $error("write answer late");
    bad_read_a: assert property (ARVALID_I && ARREADY_O && ARADDR_I == 8'h30
        |=> RRESP_O == 2'h2 && RDATA_O == 32'h0) else $error("unmapped read answered");
    bad_write_a: assert property (AWVALID_I && AWREADY_O && AWADDR_I == 8'h30 && WVALID_I
        && WREADY_O |=> BRESP_O == 2'h2) else $error("unmapped write answered");
    ready_release_a: assert property ($fell(SYS_RST_I) |=> AWREADY_O && WREADY_O && ARREADY_O)
        else $error("readies late after reset");
endmodule // cpu_status_flags_sva

bind cpu_status_flags cpu_status_flags_sva #(.DATA_W(DATA_W)) u_sva (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BRESP_O(BRESP_O),
    .BVALID_O(BVALID_O), .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
    .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .FLAGS_O(FLAGS_O),
    .BANK_SEL_O(BANK_SEL_O), .STACK_SEL_O(STACK_SEL_O), .CUR_SP_O(CUR_SP_O)
);

// [verification/tb.sv]
`timescale 1ns/1ps
`include "cpu_status_flags_map.vh"
module tb;
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    wire awready, wready, bvalid, arready, rvalid, bank, stk;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [10:0] flags;
    wire [15:0] cur_sp;
    int err_total = 0, samples_checked = 0;
    logic [2:0] opc;
    logic [15:0] a, b, res;
    logic [10:0] pre, fl;
    // opcode, a, b, preset flags, result, flags after
    logic [72:0] tbl [10] = '{
        {3'h0, 16'h1234, 16'h0000, 11'h021, 16'h0000, 11'h025},
        {3'h1, 16'h7fff, 16'h0001, 11'h000, 16'h8000, 11'h028},
        {3'h1, 16'hffff, 16'h0001, 11'h000, 16'h0000, 11'h005},
        {3'h2, 16'h0000, 16'h0001, 11'h000, 16'hffff, 11'h009},
        {3'h2, 16'h8000, 16'h0001, 11'h001, 16'h7fff, 11'h020},
        {3'h3, 16'hffff, 16'h0000, 11'h021, 16'h0000, 11'h025},
        {3'h4, 16'h8000, 16'h0001, 11'h004, 16'h8001, 11'h008},
        {3'h5, 16'h5555, 16'h5555, 11'h000, 16'h0000, 11'h004},
        {3'h6, 16'h8001, 16'h0000, 11'h020, 16'h0002, 11'h021},
        {3'h7, 16'h0001, 16'h0000, 11'h000, 16'h0000, 11'h005}};

    always #10 clk = ~clk;

    cpu_status_flags DUT (
        .CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
        .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
        .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
        .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .FLAGS_O(flags),
        .BANK_SEL_O(bank), .STACK_SEL_O(stk), .CUR_SP_O(cur_sp)
    );

    // ----------------
    // bus tasks
    // ----------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a hung handshake ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 50) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input [7:0] ad, input [31:0] d, input [3:0] s, input [1:0] er);
        int n;
        bit aw, w;
        n = 0;
        aw = 0;
        w = 0;
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            tick(n);
            if (awvalid && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) tick(n);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input [7:0] ad, input [31:0] ed, input [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) tick(n);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
    endtask

    // ----------------
    // sequence
    // ----------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_FLAGS, 0, 0);
        wr(`OFS_FLAGS, 32'hffff_fffd, 4'hf, 0);
        rd(`OFS_FLAGS, 32'h7fd, 0);
        chk({bank, stk}, 2'b11);
        wr(`OFS_USP, 32'h1234, 4'hf, 0);
        wr(`OFS_ISP, 32'habcd, 4'hf, 0);
        rd(`OFS_CUR_SP, 32'habcd, 0);
        chk(cur_sp, 16'habcd);
        wr(`OFS_FLAGS, 0, 4'hf, 0);
        rd(`OFS_CUR_SP, 32'h1234, 0);
        chk(cur_sp, 16'h1234);
        wr(8'h20, 32'h1111, 4'hf, 0);
        wr(`OFS_FLAGS, 32'h10, 4'hf, 0);
        wr(8'h20, 32'h2222, 4'hf, 0);
        rd(8'h20, 32'h2222, 0);
        wr(`OFS_FLAGS, 0, 4'hf, 0);
        rd(8'h20, 32'h1111, 0);
        wr(8'h30, 32'h5, 4'hf, `RESP_SLVERR);
        rd(8'h30, 0, `RESP_SLVERR);
        wr(`OFS_RESULT, 32'h77, 4'hf, 0);
        rd(`OFS_RESULT, 0, 0);
        // srcA reg0, srcB reg1, dest reg2
        for (int i = 0; i < 10; i++) begin
            {opc, a, b, pre, res, fl} = tbl[i];
            wr(8'h20, a, 4'hf, 0);
            wr(8'h24, b, 4'hf, 0);
            wr(`OFS_FLAGS, pre, 4'hf, 0);
            wr(`OFS_OP, 32'h240 | opc, 4'hf, 0);
            rd(`OFS_RESULT, res, 0);
            rd(8'h28, res, 0);
            rd(`OFS_FLAGS, fl, 0);
            chk(flags, fl);
        end
        // op word without its low lane: result, last op and flags all stay
        wr(`OFS_OP, 32'h241, 4'he, 0);
        rd(`OFS_RESULT, 0, 0);
        rd(`OFS_OP, 32'h247, 0);
        rd(`OFS_FLAGS, 32'h005, 0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`OFS_FLAGS, 0, 0);
        rd(`OFS_USP, 0, 0);
        chk(cur_sp, 16'h0000);
        tally_and_finish();
    end
endmodule // tb
